//--- i2c_host_pkg.sv
package i2c_host_pkg;

    // ------------------------------------------------------------
    // Target addressing
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR = 7'h1D;
    localparam logic       DIR_WRITE   = 1'h0;
    localparam logic       DIR_READ    = 1'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SCL_PERIOD_NS = 2500;
    localparam int CLK_PERIOD_NS = 20;
    localparam int QUARTER_CYC   = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QCNT_W        = 6;
    localparam logic [QCNT_W-1:0] QUARTER_LAST = QCNT_W'(QUARTER_CYC - 1);

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int LEN_W      = 5;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_BITS  = 3'h3,
        ST_STOP  = 3'h2,
        ST_WAIT  = 3'h6
    } state_t;

    typedef enum logic [2:0] {
        K_ADDR_W = 3'h0,
        K_REG    = 3'h1,
        K_ADDR_R = 3'h2,
        K_WR     = 3'h3,
        K_RD     = 3'h4
    } kind_t;

    typedef struct packed {
        logic             rd;
        logic [7:0]       reg_addr;
        logic [LEN_W-1:0] len;
    } cmd_t;

endpackage

//--- byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic [PW:0]      count_d;
    logic             in_ready_q;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready_q;
    assign pop       = out_ready && out_valid;
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_ptr_q];
    assign in_ready  = in_ready_q;
    assign count_d   = count_q + (PW+1)'(push) - (PW+1)'(pop);

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            in_ready_q <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + PW'(1);
            end
            count_q    <= count_d;
            // Full is known a cycle ahead so ready stays a flop
            in_ready_q <= (count_d < DEPTH_C);
        end
    end
endmodule

//--- i2c_host.sv
// Summary of operation
// RULE1: Start is data falling while clock stays high.
// RULE2: Target holds bus busy from start until stop.
// RULE3: First byte is seven address bits then direction, one means read.
// RULE4: Target joins only on exact address match.
// RULE5: Ninth clock of each byte is the receiver's acknowledge slot.
// RULE6: Byte sender releases data during the acknowledge slot.
// RULE7: Acknowledger holds data low through the whole clock high phase.
// RULE8: Repeated start switches from setting pointer to reading it.
// RULE9: Data rising while clock high is stop; every transfer ends so.
// RULE10: Target address is fixed; wire byte 0x3B reads, 0x3A writes.
// RULE11: Target works at fast and standard clock rates.
// RULE12: Target returns bytes most significant bit first.
// RULE13: Read opens with address-write and register index, both acknowledged.
// RULE14: After repeated start and address-read, target sends pointed register.
// RULE15: Host ends read by not acknowledging last byte, then stop.
// RULE16: Target advances pointer after each byte read.
// RULE17: Target sends while host acknowledges; stops on missing acknowledge.
// RULE18: Write is start, address-write, index, data, each acknowledged, then stop.
// RULE19: Target stores each acknowledged write byte at pointer.
// RULE20: Target leaves bus alone during others' traffic.
// RULE21: Target advances pointer after each written byte.
// RULE22: Unmatched target never acknowledges and waits for next start.
// RULE23: Target drives data only low, only in its slots.
`timescale 1ns/1ps
module i2c_host
    import i2c_host_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              cmd_valid,
    input  wire cmd_t              cmd,
    output logic                   cmd_ready,
    input  wire logic              wr_valid,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic                   wr_ready,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   rd_valid,
    output logic                   done,
    output logic                   nack_err,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe_n,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_n
);
    state_t             state_q;
    kind_t              kind_q;
    cmd_t               cmd_q;
    logic [1:0]         phase_q;
    logic [3:0]         bit_q;
    logic [7:0]         sh_q;
    logic [LEN_W-1:0]   rem_q;
    logic [QCNT_W-1:0]  qcnt_q;
    logic               sample_q;
    logic               scl_m_q, scl_s_q, sda_m_q, sda_s_q;
    logic               scl_oe_n_q, sda_oe_n_q, scl_oe_n_d, sda_oe_n_d;
    logic               cmd_ready_q, rd_valid_q, done_q, nack_q;
    logic [DATA_W-1:0]  rd_data_q;
    logic               adv, byte_end, tx_byte, drive_low, pop;
    logic               fifo_valid;
    logic [DATA_W-1:0]  fifo_data;

    // ------------------------------------------------------------
    // Write data buffer
    // ------------------------------------------------------------
    byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // ------------------------------------------------------------
    // Quarter-bit timer
    // ------------------------------------------------------------
    // High phase waits for the line to read high, so a stretching target is honoured
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            qcnt_q <= '0;
        end else if (state_q == ST_IDLE || state_q == ST_WAIT || adv) begin
            qcnt_q <= '0;
        end else if (phase_q[1] && !scl_s_q) begin
            qcnt_q <= '0;
        end else begin
            qcnt_q <= qcnt_q + QCNT_W'(1); // RULE11
        end
    end

    assign adv      = (qcnt_q == QUARTER_LAST);
    assign tx_byte  = (kind_q != K_RD);
    assign byte_end = adv && state_q == ST_BITS && phase_q == 2'h3 && bit_q == ACK_BIT;
    assign pop      = (state_q == ST_WAIT) && fifo_valid;

    // ------------------------------------------------------------
    // Line drive
    // ------------------------------------------------------------
    always_comb begin
        if (bit_q != ACK_BIT) begin
            drive_low = tx_byte && !sh_q[7];
        end else if (tx_byte) begin
            drive_low = 1'b0; // RULE6
        end else begin
            drive_low = (rem_q != LEN_W'(1)); // RULE15 RULE17
        end
    end

    // Data only changes in the second low quarter, except start and stop in the last high quarter; never beside a clock edge
    always_comb begin
        scl_oe_n_d = 1'b1;
        sda_oe_n_d = sda_oe_n_q;
        case (state_q)
            ST_IDLE: begin
                sda_oe_n_d = 1'b1;
            end
            ST_START: begin
                scl_oe_n_d = phase_q[1];
                if (phase_q == 2'h1 || phase_q == 2'h2) begin
                    sda_oe_n_d = 1'b1;
                end else if (phase_q == 2'h3) begin
                    sda_oe_n_d = 1'b0; // RULE1
                end
            end
            ST_BITS: begin
                scl_oe_n_d = phase_q[1];
                if (phase_q == 2'h1) begin
                    sda_oe_n_d = !drive_low; // RULE7
                end
            end
            ST_STOP: begin
                scl_oe_n_d = phase_q[1];
                if (phase_q == 2'h1 || phase_q == 2'h2) begin
                    sda_oe_n_d = 1'b0;
                end else if (phase_q == 2'h3) begin
                    sda_oe_n_d = 1'b1; // RULE9
                end
            end
            ST_WAIT: begin
                scl_oe_n_d = 1'b0;
            end
            default: begin
                sda_oe_n_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            scl_oe_n_q <= scl_oe_n_d;
            sda_oe_n_q <= sda_oe_n_d;
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q     <= ST_IDLE;
            kind_q      <= K_ADDR_W;
            cmd_q       <= '0;
            phase_q     <= '0;
            bit_q       <= '0;
            sh_q        <= IDLE_BYTE;
            rem_q       <= '0;
            sample_q    <= 1'b1;
            cmd_ready_q <= 1'b1;
            rd_valid_q  <= 1'b0;
            rd_data_q   <= '0;
            done_q      <= 1'b0;
            nack_q      <= 1'b0;
        end else begin
            rd_valid_q <= 1'b0;
            done_q     <= 1'b0;
            nack_q     <= 1'b0;
            if (adv && state_q != ST_IDLE && state_q != ST_WAIT) begin
                phase_q <= phase_q + 2'h1;
            end
            if (adv && phase_q == 2'h2) begin
                sample_q <= sda_s_q;
            end
            case (state_q)
                ST_IDLE: begin
                    if (cmd_valid && cmd_ready_q) begin
                        cmd_q       <= cmd;
                        cmd_ready_q <= 1'b0;
                        rem_q       <= (cmd.rd && cmd.len == '0) ? LEN_W'(1) : cmd.len;
                        kind_q      <= K_ADDR_W;
                        phase_q     <= '0;
                        state_q     <= ST_START;
                    end
                end
                ST_START: begin
                    if (adv && phase_q == 2'h3) begin
                        state_q <= ST_BITS;
                        bit_q   <= '0;
                        sh_q    <= {TARGET_ADDR, (kind_q == K_ADDR_R)}; // RULE3
                    end
                end
                ST_BITS: begin
                    if (adv && phase_q == 2'h3 && bit_q != ACK_BIT) begin
                        sh_q  <= {sh_q[6:0], sample_q};
                        bit_q <= bit_q + 4'h1;
                    end else if (byte_end) begin
                        bit_q <= '0;
                        if (tx_byte && sample_q) begin
                            nack_q  <= 1'b1; // RULE5
                            state_q <= ST_STOP;
                        end else begin
                            case (kind_q)
                                K_ADDR_W: begin
                                    kind_q <= K_REG; // RULE13
                                    sh_q   <= cmd_q.reg_addr;
                                end
                                K_REG: begin
                                    if (cmd_q.rd) begin
                                        kind_q  <= K_ADDR_R; // RULE8
                                        state_q <= ST_START;
                                    end else if (rem_q == '0) begin
                                        state_q <= ST_STOP;
                                    end else begin
                                        kind_q  <= K_WR; // RULE18
                                        state_q <= ST_WAIT;
                                    end
                                end
                                K_ADDR_R: begin
                                    kind_q <= K_RD;
                                    sh_q   <= IDLE_BYTE;
                                end
                                K_WR: begin
                                    rem_q   <= rem_q - LEN_W'(1);
                                    state_q <= (rem_q == LEN_W'(1)) ? ST_STOP : ST_WAIT;
                                end
                                default: begin
                                    rd_data_q  <= sh_q;
                                    rd_valid_q <= 1'b1;
                                    rem_q      <= rem_q - LEN_W'(1);
                                    sh_q       <= IDLE_BYTE;
                                    if (rem_q == LEN_W'(1)) begin
                                        state_q <= ST_STOP; // RULE15
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_WAIT: begin
                    // Empty buffer holds the clock low rather than sending stale data
                    if (fifo_valid) begin
                        sh_q    <= fifo_data;
                        bit_q   <= '0;
                        phase_q <= '0;
                        state_q <= ST_BITS;
                    end
                end
                ST_STOP: begin
                    if (adv && phase_q == 2'h3) begin
                        state_q     <= ST_IDLE; // RULE9
                        done_q      <= 1'b1;
                        cmd_ready_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign cmd_ready = cmd_ready_q;
    assign rd_data   = rd_data_q;
    assign rd_valid  = rd_valid_q;
    assign done      = done_q;
    assign nack_err  = nack_q;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_oe_n  = scl_oe_n_q;
    assign sda_oe_n  = sda_oe_n_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_START_ONLY_FALL: assert property ( // RULE1
        $fell(sda_oe_n_q) && scl_oe_n_q && $past(scl_oe_n_q) |-> $past(state_q) == ST_START)
        else $error("data fell under high clock outside start");
    AST_STOP_ONLY_RISE: assert property ( // RULE9
        $rose(sda_oe_n_q) && scl_oe_n_q && $past(scl_oe_n_q)
        |-> $past(state_q) == ST_STOP || $past(state_q) == ST_BITS && $past(phase_q) == 2'h1)
        else $error("data rose under high clock outside stop");
    AST_DATA_STABLE_HIGH: assert property ( // RULE7
        state_q == ST_BITS && phase_q[1] && $past(phase_q[1]) |-> $stable(sda_oe_n_q))
        else $error("data moved while clock high");
    AST_ADDR_BYTE: assert property ( // RULE3
        $past(state_q) == ST_START && state_q == ST_BITS
        |-> sh_q == {TARGET_ADDR, (kind_q == K_ADDR_R)})
        else $error("wrong address byte loaded");
    AST_TX_ACK_RELEASE: assert property ( // RULE6
        state_q == ST_BITS && bit_q == ACK_BIT && tx_byte && phase_q[1] |-> sda_oe_n_q)
        else $error("data held during target acknowledge");
    AST_LAST_NAK: assert property ( // RULE15
        state_q == ST_BITS && bit_q == ACK_BIT && kind_q == K_RD && rem_q == LEN_W'(1)
        && phase_q[1] |-> sda_oe_n_q)
        else $error("last read byte acknowledged");
    AST_MORE_ACK: assert property ( // RULE17
        state_q == ST_BITS && bit_q == ACK_BIT && kind_q == K_RD && rem_q != LEN_W'(1)
        && phase_q[1] |-> !sda_oe_n_q)
        else $error("read byte not acknowledged");
    AST_RESTART: assert property ( // RULE8
        byte_end && kind_q == K_REG && cmd_q.rd && !sample_q |=> state_q == ST_START
        && kind_q == K_ADDR_R)
        else $error("no repeated start after index");
    AST_NACK_STOP: assert property ( // RULE5
        byte_end && tx_byte && sample_q |=> state_q == ST_STOP && nack_err)
        else $error("refused byte not ended by stop");
    AST_STOP_DONE: assert property ( // RULE9
        $rose(state_q == ST_STOP) |-> ##[1:1000] done)
        else $error("stop never completed");
    AST_QUARTER: assert property ( // RULE11
        qcnt_q <= QUARTER_LAST)
        else $error("quarter timer overran");

    COV_WRITE: cover property (byte_end && kind_q == K_WR ##[1:300] done);
    COV_BURST: cover property (rd_valid ##[1:1000] rd_valid);
    COV_NACK: cover property (nack_err);
    COV_STALL: cover property (state_q == ST_WAIT && !fifo_valid);
endmodule

//--- i2c_target_model.sv
`timescale 1ns/1ps
module i2c_target_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [6:0] my_addr,
    input  wire logic       stretch,
    output logic            sda_low,
    output logic            scl_low
);
    // ------------------------------------------------------------
    // Register file and frame state
    // ------------------------------------------------------------
    logic [7:0] mem [0:255];
    logic [7:0] ptr, sh, tx;
    logic       active, rd, first, sel, idx_set;
    int         cnt;

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5C;
        sda_low = 1'b0;
        scl_low = 1'b0;
        active  = 1'b0;
        ptr     = 8'h00;
        sh      = 8'h00;
        tx      = 8'h00;
    end

    // ------------------------------------------------------------
    // Start, repeated start and stop
    // ------------------------------------------------------------
    always @(negedge sda) if (scl === 1'b1) begin
        active  = 1'b1;
        // Clock fall after start precedes bit 0, so it must not count
        cnt     = -1;
        first   = 1'b1;
        rd      = 1'b0;
        sel     = 1'b0;
        idx_set = 1'b0;
        sda_low = 1'b0;
    end

    always @(posedge sda) if (scl === 1'b1) begin
        active  = 1'b0;
        sda_low = 1'b0;
    end

    // ------------------------------------------------------------
    // Bit sampling while clock is high
    // ------------------------------------------------------------
    always @(posedge scl) if (active) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        else if (rd && !first && sda) active = 1'b0;
    end

    // ------------------------------------------------------------
    // Data line changes only while clock is low
    // ------------------------------------------------------------
    always @(negedge scl) if (active) begin
        cnt = cnt + 1;
        if (cnt == 8 && !(rd && !first)) begin
            if (first) begin
                sel = (sh[7:1] == my_addr);
                rd  = sh[0];
            end else if (!idx_set) begin
                ptr     = sh;
                idx_set = 1'b1;
            end else begin
                mem[ptr] = sh;
                ptr      = ptr + 8'h01;
            end
            sda_low = sel;
            // Unselected: silent until next start
            if (!sel) active = 1'b0;
        end else if (cnt == 8) begin
            sda_low = 1'b0;
        end else if (cnt == 9) begin
            cnt   = 0;
            first = 1'b0;
            if (rd) begin
                tx      = mem[ptr];
                ptr     = ptr + 8'h01;
                sda_low = !tx[7];
            end else begin
                sda_low = 1'b0;
            end
            // Slow target: hold clock low a while after each acknowledge slot
            if (stretch) begin
                scl_low = 1'b1;
                #2000 scl_low = 1'b0;
            end
        end else if (rd && !first) begin
            sda_low = !tx[7-cnt];
        end
    end
    // Rate independent: edge driven apart from the fixed 2000 ns stretch delay
endmodule

//--- i2c_host_tb.sv
`timescale 1ns/1ps
module i2c_host_tb;
    import i2c_host_pkg::*;

    logic       core_clk, reset, cmd_valid, wr_valid, stretch;
    cmd_t       cmd;
    logic [7:0] wr_data, rd_data;
    logic       cmd_ready, wr_ready, rd_valid, done, nack_err;
    logic       scl_o, scl_oe_n, sda_o, sda_oe_n, scl_low, sda_low;
    logic       scl_w, sda_w, saw_nack;
    logic [6:0] model_addr;
    logic [7:0] got [$];
    int         failures, n_tests, cycles;

    // ------------------------------------------------------------
    // Open-drain wires with pull-ups
    // ------------------------------------------------------------
    assign scl_w = ((scl_oe_n === 1'b0) ? scl_o : 1'b1) & !scl_low;
    assign sda_w = ((sda_oe_n === 1'b0) ? sda_o : 1'b1) & !sda_low;

    i2c_host dut (
        .core_clk (core_clk), .reset (reset), .cmd_valid (cmd_valid), .cmd (cmd),
        .cmd_ready (cmd_ready), .wr_valid (wr_valid), .wr_data (wr_data),
        .wr_ready (wr_ready), .rd_data (rd_data), .rd_valid (rd_valid), .done (done),
        .nack_err (nack_err), .scl_i (scl_w), .scl_o (scl_o), .scl_oe_n (scl_oe_n),
        .sda_i (sda_w), .sda_o (sda_o), .sda_oe_n (sda_oe_n)
    );

    i2c_target_model model (
        .scl (scl_w), .sda (sda_w), .my_addr (model_addr), .stretch (stretch),
        .sda_low (sda_low), .scl_low (scl_low)
    );

    always #10 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Hang guard, roughly 50k cycles expected
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            failures++;
            results();
        end
    end

    task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        if (failures == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic push(logic [7:0] d);
        @(posedge core_clk);
        wr_valid <= 1'b1;
        wr_data  <= d;
        @(posedge core_clk);
        wr_valid <= 1'b0;
    endtask

    // One whole frame; collects read bytes and any refusal
    task automatic run(logic rd, logic [7:0] ra, logic [4:0] len);
        int n;
        got.delete();
        saw_nack = 1'b0;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd       <= '{rd: rd, reg_addr: ra, len: len};
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
            if (rd_valid === 1'b1) got.push_back(rd_data);
            if (nack_err === 1'b1) saw_nack = 1'b1;
        end while (done !== 1'b1 && n < 40000);
        check("done", 8'h01, {7'h0, done});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("cmd_ready", 8'h01, {7'h0, cmd_ready});
        check("scl_oe_n", 8'h01, {7'h0, scl_oe_n});
        check("sda_oe_n", 8'h01, {7'h0, sda_oe_n});
        check("sda_wire", 8'h01, {7'h0, sda_w});
    endtask

    task automatic t_write_single();
        push(8'hC3);
        run(1'b0, 8'h10, 5'd1);
        check("nack", 8'h00, {7'h0, saw_nack});
        check("mem10", 8'hC3, model.mem[8'h10]);
        run(1'b0, 8'h40, 5'd0);
        check("ptr_nack", 8'h00, {7'h0, saw_nack});
        check("ptr_only", 8'h40, model.ptr);
        check("mem40_kept", 8'h40 ^ 8'h5C, model.mem[8'h40]);
    endtask

    task automatic t_fifo_burst_write();
        stretch = 1'b1;
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            @(negedge core_clk);
            check("wr_ready_fill", 8'h01, {7'h0, wr_ready});
            push(8'h80 + 8'(i));
        end
        @(negedge core_clk);
        check("wr_ready_full", 8'h00, {7'h0, wr_ready});
        run(1'b0, 8'h20, 5'd16);
        for (int i = 0; i < 16; i++)
            check("mem_burst", 8'h80 + 8'(i), model.mem[8'h20 + 8'(i)]);
        check("wr_ready_empty", 8'h01, {7'h0, wr_ready});
    endtask

    task automatic t_read_single();
        run(1'b1, 8'h10, 5'd1);
        check("rd_count", 8'h01, 8'(got.size()));
        check("rd_byte", 8'hC3, got[0]);
        run(1'b1, 8'h11, 5'd0);
        check("rd0_count", 8'h01, 8'(got.size()));
        check("rd0_byte", 8'h11 ^ 8'h5C, got[0]);
    endtask

    task automatic t_read_burst();
        logic [7:0] exp [4];
        exp = '{8'h1E ^ 8'h5C, 8'h1F ^ 8'h5C, 8'h80, 8'h81};
        run(1'b1, 8'h1E, 5'd4);
        check("burst_count", 8'h04, 8'(got.size()));
        for (int i = 0; i < 4; i++)
            check("burst_byte", exp[i], (i < got.size()) ? got[i] : 8'hXX);
        stretch = 1'b0;
    endtask

    task automatic t_addr_nack();
        model_addr = 7'h1C;
        push(8'h11);
        run(1'b0, 8'h30, 5'd1);
        check("nack_seen", 8'h01, {7'h0, saw_nack});
        check("mem30_kept", 8'h30 ^ 8'h5C, model.mem[8'h30]);
        model_addr = TARGET_ADDR;
        run(1'b0, 8'h31, 5'd1);
        check("nack_after", 8'h00, {7'h0, saw_nack});
        check("mem31", 8'h11, model.mem[8'h31]);
    endtask

    initial begin
        core_clk   = 1'b0;
        reset      = 1'b1;
        cmd_valid  = 1'b0;
        cmd        = '0;
        wr_valid   = 1'b0;
        wr_data    = 8'h00;
        stretch    = 1'b0;
        model_addr = TARGET_ADDR;
        failures   = 0;
        n_tests    = 0;
        cycles     = 0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        t_reset();
        t_write_single();
        t_fifo_burst_write();
        t_read_single();
        t_read_burst();
        t_addr_nack();
        results();
    end
endmodule
